// [mpg_pkg.sv]
// package: register map, field layout and constants of the packet test block
package mpg_pkg;

  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_CHK_ERR_HIGH = 12'h623;
  localparam logic [11:0] IDX_GEN_CTRL     = 12'h624;
  localparam logic [11:0] IDX_PAT_LOW      = 12'h625;
  localparam logic [11:0] IDX_PAT_MID      = 12'h626;
  localparam logic [11:0] IDX_PAT_HIGH     = 12'h627;
  localparam logic [11:0] IDX_DMATCH_LOW   = 12'h628;
  localparam logic [11:0] IDX_DMATCH_MID   = 12'h629;
  localparam logic [11:0] IDX_DMATCH_HIGH  = 12'h62A;
  localparam logic [11:0] IDX_CRC_FLAGS    = 12'h638;
  localparam logic [11:0] IDX_TX_CNT_LOW   = 12'h639;
  localparam logic [11:0] IDX_TX_CNT_HIGH  = 12'h63A;
  localparam logic [11:0] IDX_TX_ERR_CNT   = 12'h63B;
  localparam logic [11:0] IDX_RX_CNT_LOW   = 12'h63C;
  localparam logic [11:0] IDX_RX_CNT_HIGH  = 12'h63D;
  localparam logic [11:0] IDX_RX_ERR_CNT   = 12'h63E;
  // added registers: checker control/status and generator status
  localparam logic [11:0] IDX_CHK_CTRL     = 12'h620;
  localparam logic [11:0] IDX_GEN_STATUS   = 12'h640;

  // generator control field positions
  localparam int GC_DATA_LSB = 8;
  localparam int GC_MODE_LSB = 6;
  localparam int GC_VLD_LSB  = 3;
  localparam int GC_CNT_LSB  = 0;
  localparam logic [15:0] GEN_CTRL_RST = 16'h5511;

  // checker control bits
  localparam int CC_LOCK_BIT  = 0;
  localparam int CC_CLEAR_BIT = 1;
  localparam int CC_MODE_BIT  = 2;

  // generator status bits
  localparam int GS_DONE_BIT = 1;
  localparam int GS_BUSY_BIT = 0;

  localparam logic [1:0] MODE_INCR  = 2'h0;
  localparam logic [1:0] MODE_FIXED = 2'h1;
  localparam logic [2:0] CNT_CONT   = 3'h7;
  localparam logic [2:0] VLD_MAX    = 3'h6;

  // packet layout of generated frames
  localparam logic [15:0] PKT_LEN_BYTES = 16'h0040;
  localparam logic [7:0]  IPG_BYTES     = 8'h0C;
  localparam logic [15:0] PAT_OFFSET    = 16'h000C;
  localparam logic [7:0]  PRBS_SEED     = 8'hFF;

  typedef struct packed {
    logic [7:0] fixed_byte;
    logic [1:0] mode;
    logic [2:0] vld_bytes;
    logic [2:0] pkt_cnt;
  } mpg_gen_cfg_t;

  typedef struct packed {
    logic       valid;
    logic       sof;
    logic       eof;
    logic [7:0] data;
  } mpg_byte_t;

  // burst length for a packet-count code; zero means continuous
  function automatic logic [19:0] burst_len(input logic [2:0] code);
    case (code)
      3'h0:    burst_len = 20'h00001;
      3'h1:    burst_len = 20'h0000A;
      3'h2:    burst_len = 20'h00064;
      3'h3:    burst_len = 20'h003E8;
      3'h4:    burst_len = 20'h02710;
      3'h5:    burst_len = 20'h186A0;
      3'h6:    burst_len = 20'hF4240;
      default: burst_len = 20'h00000;
    endcase
  endfunction

endpackage

// [mpg_sat_cnt.sv]
// saturating counter with clear and wrap option
`timescale 1ns/1ps
module mpg_sat_cnt #(
  parameter int WIDTH = 16
) (
  // clock and control
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             clr_i,
  input  wire logic             inc_i,
  input  wire logic             sat_i,
  // state
  output logic [WIDTH-1:0]      count_o,
  output logic                  ovf_o
);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= '0;
      ovf_o   <= 1'b0;
    end else if (ce_i) begin
      if (clr_i) begin
        // an event in the clearing cycle is kept, not lost
        count_o <= {{(WIDTH-1){1'b0}}, inc_i};
        ovf_o   <= 1'b0;
      end else if (inc_i) begin
        if (&count_o) begin
          ovf_o <= 1'b1;
          if (!sat_i) begin
            count_o <= '0;
          end
        end else begin
          count_o <= count_o + 1'b1;
        end
      end
    end
  end

endmodule // mpg_sat_cnt

// [mpg_gen.sv]
// packet byte generator: incrementing, fixed or prbs payload with pattern
`timescale 1ns/1ps
module mpg_gen
  import mpg_pkg::*;
(
  // clock and control
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic         start_i,
  input  wire mpg_gen_cfg_t cfg_i,
  input  wire logic [47:0]  pattern_i,
  input  wire logic         tx_ready_i,
  // byte stream and status
  output mpg_byte_t         tx_o,
  output logic              busy_o,
  output logic              done_o,
  output logic              pkt_sent_o
);

  typedef enum logic [1:0] {S_IDLE, S_DATA, S_GAP} mpg_gen_st_t;

  mpg_gen_st_t st;
  logic [15:0] byte_idx;
  logic [19:0] sent;
  logic [19:0] target;
  logic [7:0]  incr;
  logic [7:0]  prbs;
  logic [7:0]  next_byte;
  logic [2:0]  vld;
  logic [15:0] pat_idx;
  logic        adv;

  assign vld     = (cfg_i.vld_bytes > VLD_MAX) ? VLD_MAX : cfg_i.vld_bytes;
  assign pat_idx = byte_idx - PAT_OFFSET;
  assign adv     = (st == S_DATA) && tx_ready_i;

  always_comb begin
    next_byte = prbs;
    if (byte_idx >= PAT_OFFSET && pat_idx < {13'h0000, vld}) begin
      next_byte = pattern_i[pat_idx[2:0]*8 +: 8];
    end else begin
      case (cfg_i.mode)
        MODE_INCR:  next_byte = incr;
        MODE_FIXED: next_byte = cfg_i.fixed_byte;
        default:    next_byte = prbs;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st         <= S_IDLE;
      byte_idx   <= '0;
      sent       <= '0;
      target     <= '0;
      busy_o     <= 1'b0;
      done_o     <= 1'b0;
      pkt_sent_o <= 1'b0;
    end else if (ce_i) begin
      pkt_sent_o <= 1'b0;
      case (st)
        S_IDLE: begin
          if (start_i) begin
            st       <= S_DATA;
            target   <= burst_len(cfg_i.pkt_cnt);
            sent     <= '0;
            byte_idx <= '0;
            busy_o   <= 1'b1;
            done_o   <= 1'b0;
          end
        end
        S_DATA: begin
          if (adv) begin
            if (byte_idx == PKT_LEN_BYTES - 16'h0001) begin
              byte_idx   <= '0;
              pkt_sent_o <= 1'b1;
              sent       <= sent + 20'h00001;
              st         <= S_GAP;
            end else begin
              byte_idx <= byte_idx + 16'h0001;
            end
          end
        end
        S_GAP: begin
          if (byte_idx[7:0] == IPG_BYTES) begin
            byte_idx <= '0;
            if (target != '0 && sent == target) begin
              st     <= S_IDLE;
              busy_o <= 1'b0;
              done_o <= 1'b1;
            end else begin
              st <= S_DATA;
            end
          end else begin
            byte_idx <= byte_idx + 16'h0001;
          end
        end
        default: st <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      incr <= '0;
      prbs <= PRBS_SEED;
    end else if (ce_i && adv) begin
      incr <= incr + 8'h01;
      // x^8+x^6+x^5+x^4+1
      prbs <= {prbs[6:0], prbs[7] ^ prbs[5] ^ prbs[4] ^ prbs[3]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_o <= '0;
    end else if (ce_i) begin
      tx_o.valid <= adv;
      tx_o.sof   <= adv && byte_idx == '0;
      tx_o.eof   <= adv && byte_idx == PKT_LEN_BYTES - 16'h0001;
      tx_o.data  <= next_byte;
    end
  end

endmodule // mpg_gen

// [mpg_top.sv]
// packet generator, checker statistics and apb register file
//
// Overview of operation
// - checker error count upper half readable
// - checker control write freezes shown count
// - count mode zero saturates error count
// - fixed mode sends programmed byte, 0x55 at reset
// - mode selects incrementing, fixed or prbs
// - valid pattern bytes 0..6, seven means six
// - count code selects burst or continuous
// - 48-bit pattern in three words
// - 48-bit destination match value compared
// - rx crc error flag
// - tx crc error flag
// - 32-bit tx packet counter, two words
// - 16-bit tx crc error counter
// - tx read sequence clears tx counters
// - rx counter, rx read sequence clears
// - lock bit freezes, clear bit also clears
// - 16-bit rx crc error counter
// - done flag after whole burst sent
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module mpg_top
  import mpg_pkg::*;
(
  // clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // apb slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [13:0]       paddr_i,
  input  wire logic [31:0]       pwdata_i,
  input  wire logic [3:0]        pstrb_i,
  output logic                   pready_o,
  output logic [31:0]            prdata_o,
  output logic                   pslverr_o,
  // generator control and stream
  input  wire logic              gen_start_i,
  input  wire logic              tx_ready_i,
  input  wire logic              tx_crc_err_i,
  output mpg_pkg::mpg_byte_t     tx_o,
  // receive side events (same clock)
  input  wire logic              rx_pkt_i,
  input  wire logic              rx_crc_err_i,
  input  wire logic [47:0]       rx_dest_i,
  input  wire logic              chk_err_pkt_i,
  // match result
  output logic                   dest_match_o
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0]  gen_ctrl;
  logic [47:0]  pattern;
  logic [47:0]  dmatch;
  logic         chk_sat_n;
  logic         tx_crc_flag;
  logic         rx_crc_flag;
  logic [15:0]  chk_err_shown;
  logic [1:0]   tx_seq;
  logic [1:0]   rx_seq;
  logic         tx_clr;
  logic         rx_clr;
  logic         chk_lock;
  logic         chk_clr;
  logic         gen_busy;
  logic         gen_done;
  logic         gen_pkt;
  logic [31:0]  chk_err_cnt;
  logic         chk_ovf;
  logic [31:0]  tx_cnt;
  logic [15:0]  tx_err_cnt;
  logic [31:0]  rx_cnt;
  logic [15:0]  rx_err_cnt;
  logic         rd_hit;
  logic         wr_hit;
  logic [11:0]  idx;
  logic [15:0]  rd_val;
  logic         rd_ok;
  mpg_gen_cfg_t cfg;
  mpg_byte_t    gen_tx;

  assign idx    = paddr_i[13:2];
  // writes land on the edge that completes the transfer
  assign wr_hit = psel_i && penable_i && pwrite_i && pready_o;
  assign rd_hit = psel_i && penable_i && !pwrite_i && !pready_o;
  assign cfg    = mpg_gen_cfg_t'({gen_ctrl[15:GC_DATA_LSB],
                                  gen_ctrl[GC_MODE_LSB +: 2],
                                  gen_ctrl[GC_VLD_LSB +: 3],
                                  gen_ctrl[GC_CNT_LSB +: 3]});

  // merge a 16-bit word under byte strobes
  function automatic logic [15:0] wmerge(input logic [15:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  st);
    wmerge = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb handshake: one wait state, answer registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
    end else if (ce_i) begin
      pready_o  <= psel_i && penable_i && !pready_o;
      pslverr_o <= psel_i && penable_i && !pready_o && !rd_ok;
      prdata_o  <= rd_hit ? {16'h0000, rd_val} : 32'h0000_0000;
    end
  end

  always_comb begin
    rd_val = 16'h0000;
    rd_ok  = 1'b1;
    case (idx)
      IDX_CHK_ERR_HIGH: rd_val = chk_err_shown;
      IDX_GEN_CTRL:     rd_val = gen_ctrl;
      IDX_PAT_LOW:      rd_val = pattern[15:0];
      IDX_PAT_MID:      rd_val = pattern[31:16];
      IDX_PAT_HIGH:     rd_val = pattern[47:32];
      IDX_DMATCH_LOW:   rd_val = dmatch[15:0];
      IDX_DMATCH_MID:   rd_val = dmatch[31:16];
      IDX_DMATCH_HIGH:  rd_val = dmatch[47:32];
      IDX_CRC_FLAGS:    rd_val = {14'h0000, rx_crc_flag, tx_crc_flag};
      IDX_TX_CNT_LOW:   rd_val = tx_cnt[15:0];
      IDX_TX_CNT_HIGH:  rd_val = tx_cnt[31:16];
      IDX_TX_ERR_CNT:   rd_val = tx_err_cnt;
      IDX_RX_CNT_LOW:   rd_val = rx_cnt[15:0];
      IDX_RX_CNT_HIGH:  rd_val = rx_cnt[31:16];
      IDX_RX_ERR_CNT:   rd_val = rx_err_cnt;
      IDX_CHK_CTRL:     rd_val = {chk_ovf, 12'h000, chk_sat_n, 2'h0};
      IDX_GEN_STATUS:   rd_val = {14'h0000, gen_done, gen_busy};
      default: begin
        rd_val = 16'h0000;
        rd_ok  = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // writable configuration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gen_ctrl  <= GEN_CTRL_RST;
      pattern   <= '0;
      dmatch    <= '0;
      chk_sat_n <= 1'b0;
    end else if (ce_i && wr_hit) begin
      case (idx)
        IDX_GEN_CTRL:    gen_ctrl <= wmerge(gen_ctrl, pwdata_i, pstrb_i);
        IDX_PAT_LOW:     pattern[15:0] <=
                           wmerge(pattern[15:0], pwdata_i, pstrb_i);
        IDX_PAT_MID:     pattern[31:16] <=
                           wmerge(pattern[31:16], pwdata_i, pstrb_i);
        IDX_PAT_HIGH:    pattern[47:32] <=
                           wmerge(pattern[47:32], pwdata_i, pstrb_i);
        IDX_DMATCH_LOW:  dmatch[15:0] <=
                           wmerge(dmatch[15:0], pwdata_i, pstrb_i);
        IDX_DMATCH_MID:  dmatch[31:16] <=
                           wmerge(dmatch[31:16], pwdata_i, pstrb_i);
        IDX_DMATCH_HIGH: dmatch[47:32] <=
                           wmerge(dmatch[47:32], pwdata_i, pstrb_i);
        IDX_CHK_CTRL: begin
          if (pstrb_i[0]) begin
            chk_sat_n <= pwdata_i[CC_MODE_BIT];
          end
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checker lock and clear strobes
  assign chk_lock = wr_hit && idx == IDX_CHK_CTRL && pstrb_i[0]
                    && (pwdata_i[CC_LOCK_BIT] || pwdata_i[CC_CLEAR_BIT]);
  assign chk_clr  = wr_hit && idx == IDX_CHK_CTRL && pstrb_i[0]
                    && pwdata_i[CC_CLEAR_BIT];

  // shown value is a snapshot taken only at lock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chk_err_shown <= '0;
    end else if (ce_i && chk_lock) begin
      chk_err_shown <= chk_clr ? 16'h0000 : chk_err_cnt[31:16];
    end
  end

  mpg_sat_cnt #(.WIDTH(32)) u_chk_err (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .clr_i   (chk_clr),
    .inc_i   (chk_err_pkt_i),
    .sat_i   (!chk_sat_n),
    .count_o (chk_err_cnt),
    .ovf_o   (chk_ovf)
  );

  ////////////////////////////////////////////////////////////////////////////
  // generator
  mpg_gen u_gen (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .start_i    (gen_start_i),
    .cfg_i      (cfg),
    .pattern_i  (pattern),
    .tx_ready_i (tx_ready_i),
    .tx_o       (gen_tx),
    .busy_o     (gen_busy),
    .done_o     (gen_done),
    .pkt_sent_o (gen_pkt)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_o <= '0;
    end else if (ce_i) begin
      tx_o <= gen_tx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read-sequence trackers; any other read restarts the sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_seq <= 2'h0;
    end else if (ce_i && rd_hit) begin
      if (idx == IDX_TX_CNT_LOW) begin
        tx_seq <= 2'h1;
      end else if (idx == IDX_TX_CNT_HIGH && tx_seq == 2'h1) begin
        tx_seq <= 2'h2;
      end else begin
        tx_seq <= 2'h0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_seq <= 2'h0;
    end else if (ce_i && rd_hit) begin
      if (idx == IDX_RX_CNT_LOW) begin
        rx_seq <= 2'h1;
      end else if (idx == IDX_RX_CNT_HIGH && rx_seq == 2'h1) begin
        rx_seq <= 2'h2;
      end else begin
        rx_seq <= 2'h0;
      end
    end
  end

  assign tx_clr = rd_hit && idx == IDX_TX_ERR_CNT && tx_seq == 2'h2;
  assign rx_clr = rd_hit && idx == IDX_RX_ERR_CNT && rx_seq == 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // statistics counters
  mpg_sat_cnt #(.WIDTH(32)) u_tx_cnt (
    .clk_i (clk_i), .rst_i (rst_i), .ce_i (ce_i),
    .clr_i (tx_clr), .inc_i (gen_pkt), .sat_i (1'b1),
    .count_o (tx_cnt), .ovf_o ()
  );

  mpg_sat_cnt #(.WIDTH(16)) u_tx_err (
    .clk_i (clk_i), .rst_i (rst_i), .ce_i (ce_i),
    .clr_i (tx_clr), .inc_i (tx_crc_err_i), .sat_i (1'b1),
    .count_o (tx_err_cnt), .ovf_o ()
  );

  mpg_sat_cnt #(.WIDTH(32)) u_rx_cnt (
    .clk_i (clk_i), .rst_i (rst_i), .ce_i (ce_i),
    .clr_i (rx_clr), .inc_i (rx_pkt_i), .sat_i (1'b1),
    .count_o (rx_cnt), .ovf_o ()
  );

  mpg_sat_cnt #(.WIDTH(16)) u_rx_err (
    .clk_i (clk_i), .rst_i (rst_i), .ce_i (ce_i),
    .clr_i (rx_clr), .inc_i (rx_crc_err_i), .sat_i (1'b1),
    .count_o (rx_err_cnt), .ovf_o ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // crc flags follow the latest packet; destination match
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_crc_flag  <= 1'b0;
      rx_crc_flag  <= 1'b0;
      dest_match_o <= 1'b0;
    end else if (ce_i) begin
      // sampled as the packet end leaves the block toward the link
      if (tx_o.valid && tx_o.eof) begin
        tx_crc_flag <= tx_crc_err_i;
      end
      if (rx_pkt_i) begin
        rx_crc_flag  <= rx_crc_err_i;
        dest_match_o <= rx_dest_i == dmatch;
      end
    end
  end

endmodule // mpg_top

// [mpg_top_sva.sv]
// port assertions of the packet test block
`timescale 1ns/1ps
module mpg_top_chk
  import mpg_pkg::*;
(
  // clock and reset
  input wire logic               clk_i,
  input wire logic               rst_i,
  // apb
  input wire logic               psel_i,
  input wire logic               penable_i,
  input wire logic               pready_o,
  input wire logic [31:0]        prdata_o,
  input wire logic               pslverr_o,
  // stream and receive
  input wire mpg_pkg::mpg_byte_t tx_o,
  input wire logic               rx_pkt_i,
  input wire logic               dest_match_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_next_a: assert property (
    psel_i && penable_i && !pready_o |=> pready_o)
    else $error("no ready after access");
  ack_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  ack_cause_a: assert property (
    pready_o |-> $past(psel_i) && $past(penable_i))
    else $error("ready without access");
  err_data_a: assert property (
    pslverr_o |-> pready_o && prdata_o == 32'h0)
    else $error("bad error response");
  read_width_a: assert property (
    pready_o |-> prdata_o[31:16] == 16'h0000)
    else $error("read data above 16 bits");
  match_cause_a: assert property (
    !$stable(dest_match_o) |-> $past(rx_pkt_i))
    else $error("match changed without packet");
  frame_start_a: assert property (
    tx_o.sof |-> tx_o.valid ##1 !tx_o.sof [*8])
    else $error("bad packet start");
  frame_end_a: assert property (tx_o.eof |-> tx_o.valid)
    else $error("end marker without byte");
endmodule // mpg_top_chk

bind mpg_top mpg_top_chk chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pready_o(pready_o),
  .prdata_o(prdata_o),
  .pslverr_o(pslverr_o),
  .tx_o(tx_o),
  .rx_pkt_i(rx_pkt_i),
  .dest_match_o(dest_match_o)
);

// [mpg_link_model.sv]
// model of the copper link beyond the packet stream
`timescale 1ns/1ps
module mpg_link_model
  import mpg_pkg::*;
(
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // transmit side
  input  wire mpg_pkg::mpg_byte_t tx_i,
  input  wire logic               stall_i,
  input  wire logic               bad_tx_i,
  output logic                    tx_ready_o,
  output logic                    tx_crc_err_o,
  // receive side
  input  wire logic               rx_go_i,
  input  wire logic               rx_bad_i,
  input  wire logic [47:0]        rx_da_i,
  output logic                    rx_pkt_o,
  output logic                    rx_crc_err_o,
  output logic [47:0]             rx_dest_o
);
  logic [7:0]  pkt_bytes [0:127];
  logic [15:0] n_byte;
  logic        phase;

  // slow sink: refuses every other cycle
  always_ff @(posedge clk_i) begin
    phase <= rst_i ? 1'h0 : !phase;
  end
  assign tx_ready_o = !(stall_i && phase);
  assign tx_crc_err_o = tx_i.valid && tx_i.eof && bad_tx_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      n_byte <= 16'h0000;
    end else if (tx_i.valid) begin
      pkt_bytes[tx_i.sof ? 7'h00 : n_byte[6:0]] <= tx_i.data;
      n_byte <= tx_i.sof ? 16'h0001 : n_byte + 16'h0001;
    end
  end

  // address only valid with the packet pulse
  always_ff @(posedge clk_i) begin
    rx_pkt_o <= !rst_i && rx_go_i;
    rx_crc_err_o <= !rst_i && rx_go_i && rx_bad_i;
    rx_dest_o <= rx_go_i ? rx_da_i : ~rx_dest_o;
  end
endmodule // mpg_link_model

// [test_mpg_top.sv]
// self-checking bench of the packet test block
`timescale 1ns/1ps
module test_mpg_top;
  import mpg_pkg::*;
  typedef struct packed {
    logic        w;
    logic [11:0] idx;
    logic [15:0] wd;
    logic [15:0] exp;
  } mpg_row_t;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h0;
  logic        gen_start = 1'h0;
  logic        chk_err = 1'h0;
  logic        stall = 1'h0;
  logic        bad_tx = 1'h0;
  logic        rx_go = 1'h0;
  logic        rx_bad = 1'h0;
  logic [47:0] rx_da = 48'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, tx_ready, tx_crc_err, err;
  logic        rx_pkt, rx_crc_err, dest_match;
  logic [47:0] rx_dest;
  logic [47:0] pat = 48'hBC9A78563412;
  mpg_byte_t   tx;
  int          n_mismatch = 0;
  int          checked = 0;
  int          cyc = 0;
  mpg_row_t    rows [0:15] = '{
    '{1'h0, IDX_GEN_CTRL, 16'h0, 16'h5511}, '{1'h0, IDX_PAT_LOW, 16'h0, 16'h0},
    '{1'h0, IDX_DMATCH_HIGH, 16'h0, 16'h0}, '{1'h0, IDX_CRC_FLAGS, 16'h0, 16'h0},
    '{1'h0, IDX_TX_CNT_LOW, 16'h0, 16'h0}, '{1'h1, IDX_CHK_ERR_HIGH, 16'hFFFF, 16'h0},
    '{1'h0, IDX_CHK_ERR_HIGH, 16'h0, 16'h0}, '{1'h1, IDX_PAT_LOW, 16'h3412, 16'h0},
    '{1'h1, IDX_PAT_MID, 16'h7856, 16'h0}, '{1'h1, IDX_PAT_HIGH, 16'hBC9A, 16'h0},
    '{1'h0, IDX_PAT_HIGH, 16'h0, 16'hBC9A}, '{1'h0, IDX_PAT_LOW, 16'h0, 16'h3412},
    '{1'h1, IDX_DMATCH_LOW, 16'h2211, 16'h0}, '{1'h1, IDX_DMATCH_MID, 16'h4433, 16'h0},
    '{1'h1, IDX_DMATCH_HIGH, 16'h6655, 16'h0}, '{1'h0, IDX_DMATCH_MID, 16'h0, 16'h4433}};

  mpg_top uut (.clk_i(clk), .rst_i(rst), .ce_i(1'h1), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(4'h3), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .gen_start_i(gen_start),
    .tx_ready_i(tx_ready), .tx_crc_err_i(tx_crc_err), .tx_o(tx),
    .rx_pkt_i(rx_pkt), .rx_crc_err_i(rx_crc_err), .rx_dest_i(rx_dest),
    .chk_err_pkt_i(chk_err), .dest_match_o(dest_match));
  mpg_link_model link (.clk_i(clk), .rst_i(rst), .tx_i(tx),
    .stall_i(stall), .bad_tx_i(bad_tx), .tx_ready_o(tx_ready),
    .tx_crc_err_o(tx_crc_err), .rx_go_i(rx_go), .rx_bad_i(rx_bad),
    .rx_da_i(rx_da), .rx_pkt_o(rx_pkt), .rx_crc_err_o(rx_crc_err),
    .rx_dest_o(rx_dest));

  initial begin
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (n_mismatch == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] idx,
                     input logic [15:0] wd);
    int n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {16'h0, wd};
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rchk(input logic [11:0] idx, input logic [15:0] exp);
    apb(1'h0, idx, 16'h0);
    chk($sformatf("reg %h", idx), rd, {16'h0, exp});
  endtask

  task automatic burst;
    int n = 0;
    @(posedge clk);
    gen_start <= 1'h1;
    @(posedge clk);
    gen_start <= 1'h0;
    do begin
      apb(1'h0, IDX_GEN_STATUS, 16'h0);
      n++;
    end while (rd[GS_DONE_BIT] !== 1'h1 && n < 1000);
    chk("done", {31'h0, rd[GS_DONE_BIT]}, 32'h1);
  endtask

  task automatic rx(input logic [47:0] da, input logic bad, m);
    @(posedge clk);
    rx_da <= da;
    rx_bad <= bad;
    rx_go <= 1'h1;
    @(posedge clk);
    rx_go <= 1'h0;
    repeat (3) @(posedge clk);
    chk("match", {31'h0, dest_match}, {31'h0, m});
  endtask

  function automatic logic [7:0] fix_exp(input int m, input int k);
    if (k >= 12 && k < 18) return pat[8*(k-12) +: 8];
    return (m == 0) ? k[7:0] : 8'hA5;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].idx, rows[i].wd);
      chk("reg err", {31'h0, err}, 32'h0);
      if (!rows[i].w) begin
        chk("reg", rd, {16'h0, rows[i].exp});
      end
    end
    apb(1'h0, 12'h700, 16'h0);
    chk("unmapped", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    for (int m = 0; m < 4; m++) begin
      apb(1'h1, IDX_GEN_CTRL, {8'hA5, m[1:0], 3'h7, 3'h0});
      burst();
      chk("bytes", {16'h0, link.n_byte}, {16'h0, PKT_LEN_BYTES});
      for (int k = 0; k < 64 && m < 2; k++) begin
        chk("payload", {24'h0, link.pkt_bytes[k]},
            {24'h0, fix_exp(m, k)});
      end
    end
    stall <= 1'h1;
    bad_tx <= 1'h1;
    apb(1'h1, IDX_GEN_CTRL, {8'hA5, MODE_INCR, 3'h2, 3'h1});
    burst();
    stall <= 1'h0;
    bad_tx <= 1'h0;
    rchk(IDX_TX_CNT_LOW, 16'h000E);
    rchk(IDX_CRC_FLAGS, 16'h0001);
    rchk(IDX_TX_CNT_HIGH, 16'h0000);
    rchk(IDX_TX_ERR_CNT, 16'h000A);
    rchk(IDX_TX_CNT_LOW, 16'h000E);
    rchk(IDX_TX_CNT_HIGH, 16'h0000);
    rchk(IDX_TX_ERR_CNT, 16'h000A);
    rchk(IDX_TX_CNT_LOW, 16'h0000);
    rchk(IDX_TX_ERR_CNT, 16'h0000);
    rx(48'h665544332211, 1'h0, 1'h1);
    rx(48'h665544332210, 1'h0, 1'h0);
    rx(48'h665544332211, 1'h1, 1'h1);
    rchk(IDX_CRC_FLAGS, 16'h0003);
    rchk(IDX_RX_CNT_LOW, 16'h0003);
    rchk(IDX_RX_CNT_HIGH, 16'h0000);
    rchk(IDX_RX_ERR_CNT, 16'h0001);
    rchk(IDX_RX_CNT_LOW, 16'h0000);
    repeat (5) begin
      @(posedge clk);
      chk_err <= 1'h1;
      @(posedge clk);
      chk_err <= 1'h0;
    end
    apb(1'h1, IDX_CHK_CTRL, 16'h0001);
    rchk(IDX_CHK_ERR_HIGH, 16'h0000);
    @(posedge clk);
    chk_err <= 1'h1;
    repeat (65536) @(posedge clk);
    chk_err <= 1'h0;
    rchk(IDX_CHK_ERR_HIGH, 16'h0000);
    apb(1'h1, IDX_CHK_CTRL, 16'h0005);
    rchk(IDX_CHK_ERR_HIGH, 16'h0001);
    rchk(IDX_CHK_CTRL, 16'h0004);
    apb(1'h1, IDX_CHK_CTRL, 16'h0002);
    rchk(IDX_CHK_ERR_HIGH, 16'h0000);
    rchk(IDX_CHK_CTRL, 16'h0000);
    stop_test();
  end
endmodule // test_mpg_top
